// [rtl/sgps_supervisor.sv]
/*
 * Switchgear position supervisor: filters the closed and open auxiliary
 * contacts, times close and open travel, and derives closed, open,
 * in-transit and faulted flags plus a two-bit state code. Registers sit
 * on a plain strobe port; one level interrupt reports events.
 * Assumes commands are one-cycle pulses on sys_clk and contacts are
 * asynchronous pins.
 */
// Our own choices: the register addresses and strobed register access.
module sgps_supervisor #(
	parameter logic [23:0] CLOSE_LEN_DEF = sgps_pkg::SGPS_LEN_RESET,
	parameter logic [23:0] OPEN_LEN_DEF = sgps_pkg::SGPS_LEN_RESET
) (
	input wire logic sys_clk, // System clock, 200 MHz
	input wire logic reset, // Synchronous reset, active high
	input wire logic aux_closed_in, // Closed-position contact pin
	input wire logic aux_open_in, // Open-position contact pin
	input wire logic cmd_close, // Close command pulse
	input wire logic cmd_open, // Open command pulse, wins a tie
	input wire logic [7:0] reg_addr, // Register byte address
	input wire logic [31:0] reg_wdata, // Register write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [31:0] reg_rdata, // Read data, cycle after strobe
	output logic pos_closed, // Closed flag
	output logic pos_open, // Open flag
	output logic pos_transit, // In-transit flag
	output logic pos_faulted, // Faulted flag
	output logic [1:0] pos_code, // State code
	output logic irq // Level interrupt
);
	import sgps_pkg::*;

	// Decode the filtered contacts; an unwired contact is inferred from
	// the other, and a running timer makes the inferred side uncertain
	function automatic sgps_pos_t pos_decode(input logic on, input logic off,
		input logic on_w, input logic off_w, input logic close_run,
		input logic open_run);
		sgps_pos_t p;
		p = SGPS_POS_INVALID;
		if (on_w && off_w) begin
			if (on && !off) p = SGPS_POS_CLOSED;
			else if (!on && off) p = SGPS_POS_OPEN;
		end else if (on_w) begin
			if (on) p = SGPS_POS_CLOSED;
			else if (!close_run) p = SGPS_POS_OPEN;
		end else if (off_w) begin
			if (off) p = SGPS_POS_OPEN;
			else if (!open_run) p = SGPS_POS_CLOSED;
		end else begin
			p = SGPS_POS_UNWIRED;
		end
		return p;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Contact inputs and timers

	logic on_lvl, off_lvl;
	logic close_run, open_run, close_exp, open_exp;
	logic close_start, open_start, close_stop, open_stop;
	logic [1:0] ctrl_reg, ctrl_next;
	logic [23:0] close_len_reg, close_len_next;
	logic [23:0] open_len_reg, open_len_next;
	sgps_pos_t pos;
	logic end_reached, pos_valid;

	sgps_contact_sync u_sync_on (
		.sys_clk(sys_clk),
		.reset(reset),
		.pin_in(aux_closed_in),
		.level_out(on_lvl)
	);

	sgps_contact_sync u_sync_off (
		.sys_clk(sys_clk),
		.reset(reset),
		.pin_in(aux_open_in),
		.level_out(off_lvl)
	);

	// Each direction is supervised only if its own contact is wired;
	// a single contact cannot judge the opposite travel
	assign close_start = cmd_close && !cmd_open
		&& ctrl_reg[SGPS_CTRL_ON_WIRED];
	assign open_start = cmd_open
		&& ctrl_reg[SGPS_CTRL_OFF_WIRED];

	// Continuous evaluation of the position
	assign pos = pos_decode(on_lvl, off_lvl, ctrl_reg[SGPS_CTRL_ON_WIRED],
		ctrl_reg[SGPS_CTRL_OFF_WIRED], close_run, open_run);
	assign pos_valid = (pos == SGPS_POS_OPEN) || (pos == SGPS_POS_CLOSED);
	assign end_reached = (close_run && pos == SGPS_POS_CLOSED)
		|| (open_run && pos == SGPS_POS_OPEN);

	// An open command, or a close command that starts the close timer, stops the timer of the other direction
	assign close_stop = (close_run && pos == SGPS_POS_CLOSED)
		|| cmd_open;
	assign open_stop = (open_run && pos == SGPS_POS_OPEN)
		|| close_start;

	sgps_travel_timer u_close_timer (
		.sys_clk(sys_clk),
		.reset(reset),
		.start(close_start),
		.stop(close_stop),
		.len(close_len_reg),
		.running(close_run),
		.expired(close_exp)
	);

	sgps_travel_timer u_open_timer (
		.sys_clk(sys_clk),
		.reset(reset),
		.start(open_start),
		.stop(open_stop),
		.len(open_len_reg),
		.running(open_run),
		.expired(open_exp)
	);

	////////////////////////////////////////////////////////////////////////
	// Position flags and fault latch

	logic fault_reg, fault_next, prev_valid_reg;
	logic closed_reg, closed_next, open_reg, open_next;
	logic transit_reg, transit_next, faulted_reg, faulted_next;
	logic [1:0] code_reg, code_next;
	logic fault_set, fault_clr;

	assign fault_set = close_exp || open_exp;
	// Clearing on the entry into a valid position, not its level, keeps a
	// fault visible when a travel ran out against the wrong end stop
	assign fault_clr = close_start || open_start
		|| (pos_valid && !prev_valid_reg);

	always_comb begin
		fault_next = fault_reg;
		if (fault_set) fault_next = 1'b1;
		else if (fault_clr) fault_next = 1'b0;
		closed_next = 1'b0;
		open_next = 1'b0;
		transit_next = 1'b0;
		faulted_next = 1'b0;
		code_next = SGPS_CODE_INTERMEDIATE;
		if (pos == SGPS_POS_UNWIRED) begin
			faulted_next = 1'b1;
			code_next = SGPS_CODE_FAULTED;
		end else if ((close_run || open_run) && !end_reached) begin
			transit_next = 1'b1;
		end else if (fault_next) begin
			faulted_next = 1'b1;
			code_next = SGPS_CODE_FAULTED;
		end else if (pos == SGPS_POS_OPEN) begin
			open_next = 1'b1;
			code_next = SGPS_CODE_OPEN;
		end else if (pos == SGPS_POS_CLOSED) begin
			closed_next = 1'b1;
			code_next = SGPS_CODE_CLOSED;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			fault_reg <= 1'b0;
			prev_valid_reg <= 1'b0;
			closed_reg <= 1'b0;
			open_reg <= 1'b0;
			transit_reg <= 1'b0;
			faulted_reg <= 1'b0;
			code_reg <= SGPS_CODE_INTERMEDIATE;
		end else begin
			fault_reg <= fault_next;
			prev_valid_reg <= pos_valid;
			closed_reg <= closed_next;
			open_reg <= open_next;
			transit_reg <= transit_next;
			faulted_reg <= faulted_next;
			code_reg <= code_next;
		end
	end

	assign pos_closed = closed_reg;
	assign pos_open = open_reg;
	assign pos_transit = transit_reg;
	assign pos_faulted = faulted_reg;
	assign pos_code = code_reg;

	////////////////////////////////////////////////////////////////////////
	// Register port and interrupt

	logic [2:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
	logic [2:0] ev, w1c;
	logic [31:0] rdata_reg, rdata_next;

	assign ev = {fault_set, open_next && !open_reg,
		closed_next && !closed_reg};
	assign w1c = (reg_wr && reg_addr == SGPS_OFS_IRQ_STAT)
		? reg_wdata[2:0] : 3'h0;

	// Writes, sticky events and read mux; a new event beats its own clear
	always_comb begin
		ctrl_next = ctrl_reg;
		close_len_next = close_len_reg;
		open_len_next = open_len_reg;
		irq_mask_next = irq_mask_reg;
		irq_stat_next = (irq_stat_reg & ~w1c) | ev;
		rdata_next = 32'h00000000;
		if (reg_wr) begin
			unique case (reg_addr)
				SGPS_OFS_CTRL: ctrl_next = reg_wdata[1:0];
				SGPS_OFS_CLOSE_LEN: close_len_next = reg_wdata[23:0];
				SGPS_OFS_OPEN_LEN: open_len_next = reg_wdata[23:0];
				SGPS_OFS_IRQ_MASK: irq_mask_next = reg_wdata[2:0];
				default: ;
			endcase
		end
		if (reg_rd) begin
			unique case (reg_addr)
				SGPS_OFS_CTRL: rdata_next = {30'h0, ctrl_reg};
				SGPS_OFS_CLOSE_LEN: rdata_next = {8'h00, close_len_reg};
				SGPS_OFS_OPEN_LEN: rdata_next = {8'h00, open_len_reg};
				SGPS_OFS_STATUS: rdata_next = {24'h000000, open_run, close_run,
					code_reg, faulted_reg, transit_reg, open_reg, closed_reg};
				SGPS_OFS_IRQ_STAT: rdata_next = {29'h0, irq_stat_reg};
				SGPS_OFS_IRQ_MASK: rdata_next = {29'h0, irq_mask_reg};
				default: rdata_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ctrl_reg <= SGPS_CTRL_RESET;
			close_len_reg <= CLOSE_LEN_DEF;
			open_len_reg <= OPEN_LEN_DEF;
			irq_stat_reg <= 3'h0;
			irq_mask_reg <= SGPS_IRQ_MASK_RESET;
			rdata_reg <= 32'h00000000;
		end else begin
			ctrl_reg <= ctrl_next;
			close_len_reg <= close_len_next;
			open_len_reg <= open_len_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign irq = |(irq_stat_reg & irq_mask_reg);

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_close_timer_starts: assert property (
		close_start |=> close_run)
		else $error("Close command did not start the close timer");

	a_open_timer_starts: assert property (
		open_start |=> open_run)
		else $error("Open command did not start the open timer");

	a_closed_on_feedback: assert property (
		(close_run && pos == SGPS_POS_CLOSED && !cmd_open && !fault_set)
		|=> closed_reg && !transit_reg && code_reg == SGPS_CODE_CLOSED)
		else $error("Closed feedback not shown");

	a_open_on_feedback: assert property (
		(open_run && pos == SGPS_POS_OPEN && !close_start && !fault_set)
		|=> open_reg && !transit_reg && code_reg == SGPS_CODE_OPEN)
		else $error("Open feedback not shown");

	a_expiry_faults: assert property (
		(fault_set && !close_start && !open_start)
		|=> fault_reg ##1 (!transit_reg || close_run || open_run))
		else $error("Timer run-out did not raise the fault");

	a_transit_outputs: assert property (
		transit_reg |-> !closed_reg && !open_reg && !faulted_reg
		&& code_reg == SGPS_CODE_INTERMEDIATE)
		else $error("In-transit outputs inconsistent");

	a_code_matches_flags: assert property (
		(code_reg == SGPS_CODE_CLOSED) == closed_reg
		&& (code_reg == SGPS_CODE_OPEN) == open_reg
		&& (code_reg == SGPS_CODE_FAULTED) == faulted_reg)
		else $error("State code disagrees with flags");

	a_single_contact_timed: assert property (
		(cmd_close && !cmd_open && ctrl_reg == 2'h1) |=> close_run)
		else $error("Single contact close not supervised");

	a_fault_holds: assert property (
		(fault_reg && !fault_clr) |=> fault_reg)
		else $error("Fault latch dropped without cause");

	a_cmd_stops_other: assert property (
		open_start |=> !close_run && open_run)
		else $error("Open command left the close timer running");

	c_close_success: cover property (close_run ##[1:64] closed_reg);
	c_open_success: cover property (open_run ##[1:64] open_reg);
	c_travel_fault: cover property (fault_set ##2 faulted_reg);
	c_irq_raised: cover property (!irq ##1 irq);

endmodule

// [rtl/sgps_pkg.sv]
/*
 * Constants shared by the switchgear position supervisor: register map,
 * field positions, reset values, position kinds and state codes.
 * Assumes a single 200 MHz system clock and a synchronous reset.
 */
package sgps_pkg;

	// Register byte offsets
	localparam logic [7:0] SGPS_OFS_CTRL = 8'h00;
	localparam logic [7:0] SGPS_OFS_CLOSE_LEN = 8'h04;
	localparam logic [7:0] SGPS_OFS_OPEN_LEN = 8'h08;
	localparam logic [7:0] SGPS_OFS_STATUS = 8'h0c;
	localparam logic [7:0] SGPS_OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] SGPS_OFS_IRQ_MASK = 8'h14;

	// Control fields
	localparam int SGPS_CTRL_ON_WIRED = 0;
	localparam int SGPS_CTRL_OFF_WIRED = 1;
	localparam logic [1:0] SGPS_CTRL_RESET = 2'h3;

	// Status fields
	localparam int SGPS_ST_CLOSED = 0;
	localparam int SGPS_ST_OPEN = 1;
	localparam int SGPS_ST_TRANSIT = 2;
	localparam int SGPS_ST_FAULTED = 3;
	localparam int SGPS_ST_CODE = 4;
	localparam int SGPS_ST_CLOSE_RUN = 6;
	localparam int SGPS_ST_OPEN_RUN = 7;

	// Interrupt events
	localparam int SGPS_EV_CLOSED = 0;
	localparam int SGPS_EV_OPEN = 1;
	localparam int SGPS_EV_FAULT = 2;
	localparam logic [2:0] SGPS_IRQ_MASK_RESET = 3'h0;

	// Travel timers, counted in system clock cycles
	localparam int SGPS_LEN_W = 24;
	localparam logic [SGPS_LEN_W-1:0] SGPS_LEN_RESET = 24'h0f4240;

	// Position kinds seen at the contacts
	typedef enum logic [1:0] {
		SGPS_POS_INVALID = 2'h0,
		SGPS_POS_OPEN = 2'h1,
		SGPS_POS_CLOSED = 2'h2,
		SGPS_POS_UNWIRED = 2'h3
	} sgps_pos_t;

	// State codes presented to the consumers
	localparam logic [1:0] SGPS_CODE_INTERMEDIATE = 2'h0;
	localparam logic [1:0] SGPS_CODE_OPEN = 2'h1;
	localparam logic [1:0] SGPS_CODE_CLOSED = 2'h2;
	localparam logic [1:0] SGPS_CODE_FAULTED = 2'h3;

endpackage

// [rtl/sgps_contact_sync.sv]
/*
 * Three-stage synchroniser for one auxiliary contact input.
 * Assumes the contact is asynchronous to sys_clk; the filtered level
 * moves only once the second and third stages agree.
 */
module sgps_contact_sync (
	input wire logic sys_clk, // System clock
	input wire logic reset, // Synchronous reset, active high
	input wire logic pin_in, // Raw contact level
	output logic level_out // Filtered contact level
);
	import sgps_pkg::*;

	logic s1_reg, s2_reg, s3_reg, out_reg;
	logic out_next;

	// Agreement of the late stages gates the update, so one glitch cannot
	// slip through; the first stage feeds only the second
	always_comb begin
		out_next = out_reg;
		if (s2_reg == s3_reg) begin
			out_next = s3_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			out_reg <= 1'b0;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			out_reg <= out_next;
		end
	end

	assign level_out = out_reg;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_sync_agree_gate: assert property (
		(out_reg != $past(out_reg)) |-> $past(s2_reg == s3_reg))
		else $error("Contact level moved without stage agreement");

endmodule

// [rtl/sgps_travel_timer.sv]
/*
 * One travel timer: counts a programmed number of cycles after a start
 * pulse and pulses expired if not stopped first. Stop beats expiry.
 * Assumes start and stop come from logic on the same clock.
 */
module sgps_travel_timer (
	input wire logic sys_clk, // System clock
	input wire logic reset, // Synchronous reset, active high
	input wire logic start, // Restart pulse
	input wire logic stop, // Abort, end position reached
	input wire logic [23:0] len, // Travel time in cycles
	output logic running, // Timer counting
	output logic expired // One-cycle pulse on run-out
);
	import sgps_pkg::*;

	logic [SGPS_LEN_W-1:0] cnt_reg, cnt_next;
	logic run_reg, run_next, exp_reg, exp_next;

	// A zero length is taken as one cycle so a timer always ends
	always_comb begin
		cnt_next = cnt_reg;
		run_next = run_reg;
		exp_next = 1'b0;
		if (start) begin
			run_next = 1'b1;
			cnt_next = (len == '0) ? 24'h000001 : len;
		end else if (run_reg && stop) begin
			run_next = 1'b0;
		end else if (run_reg) begin
			cnt_next = cnt_reg - 24'h000001;
			if (cnt_reg == 24'h000001) begin
				run_next = 1'b0;
				exp_next = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cnt_reg <= '0;
			run_reg <= 1'b0;
			exp_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			run_reg <= run_next;
			exp_reg <= exp_next;
		end
	end

	assign running = run_reg;
	assign expired = exp_reg;

endmodule

// [test/sgps_gear_model.sv]
/*
 * Behavioural switchgear: two auxiliary position contacts that part on a
 * command and, after a travel time, make the commanded end stop.
 * Assumes commands are one-cycle pulses on sys_clk; mode is set by the
 * bench between operations.
 */
module sgps_gear_model (
	input wire logic sys_clk, // System clock
	input wire logic reset, // Synchronous reset, active high
	input wire logic cmd_close, // Close command seen at the gear
	input wire logic cmd_open, // Open command, wins a tie
	input wire logic [1:0] mode, // 0 moves, 1 stuck apart, 2 stuck made
	input wire logic [7:0] travel, // Cycles between parting and end stop
	output logic aux_closed, // Closed-position contact
	output logic aux_open // Open-position contact
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] left;
	logic target_closed;
	logic moving;

	////////////////////////////////////////////////////////////////////////
	// Mechanism; a stuck gear never reaches an end stop, so the
	// supervisor's timer or a new command is all that can end the travel
	always @(posedge sys_clk) begin
		if (reset) begin
			aux_closed <= 1'b0;
			aux_open <= 1'b1;
			moving <= 1'b0;
			left <= 8'h00;
			target_closed <= 1'b0;
		end else if (cmd_open || cmd_close) begin
			target_closed <= !cmd_open;
			moving <= (mode == 2'h0);
			left <= travel;
			aux_closed <= (mode == 2'h2);
			aux_open <= (mode == 2'h2);
		end else if (moving) begin
			if (left == 8'h00) begin
				moving <= 1'b0;
				aux_closed <= target_closed;
				aux_open <= !target_closed;
			end else begin
				left <= left - 8'h01;
			end
		end
	end
endmodule

// [test/tb_sgps_supervisor.sv]
/*
 * Self-checking bench for the position supervisor with a gear model.
 * Assumes short travel lengths of 16 cycles set through the parameters.
 */
module tb_sgps_supervisor;
	timeunit 1ns;
	timeprecision 1ps;
	import sgps_pkg::*;

	localparam logic [23:0] LEN = 24'h000010;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic cmd_close = 1'b0;
	logic cmd_open = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic pos_closed, pos_open, pos_transit, pos_faulted, irq;
	logic [1:0] pos_code;
	logic aux_closed, aux_open;
	logic [1:0] mode = 2'h0;
	logic [7:0] travel = 8'h06;
	logic [31:0] rd;
	int n_mismatch = 0;
	int total_checks = 0;
	int cycles = 0;

	sgps_supervisor #(.CLOSE_LEN_DEF(LEN), .OPEN_LEN_DEF(LEN)) dut_u (
		.sys_clk(sys_clk), .reset(reset), .aux_closed_in(aux_closed),
		.aux_open_in(aux_open), .cmd_close(cmd_close), .cmd_open(cmd_open),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .pos_closed(pos_closed),
		.pos_open(pos_open), .pos_transit(pos_transit),
		.pos_faulted(pos_faulted), .pos_code(pos_code), .irq(irq));

	sgps_gear_model gear_u (.sys_clk(sys_clk), .reset(reset),
		.cmd_close(cmd_close), .cmd_open(cmd_open), .mode(mode),
		.travel(travel), .aux_closed(aux_closed), .aux_open(aux_open));

	////////////////////////////////////////////////////////////////////////
	// Clock and hang guard; the whole run needs well under 2000 cycles
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared helpers
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic pulse(input logic close);
		@(posedge sys_clk);
		cmd_close <= close;
		cmd_open <= !close;
		@(posedge sys_clk);
		cmd_close <= 1'b0;
		cmd_open <= 1'b0;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	// Bounded wait for an end position flag
	task automatic wait_end(input logic closed);
		for (int i = 0; i < 40; i++) begin
			if ((closed ? pos_closed : pos_open) === 1'b1) break;
			cyc(1);
		end
	endtask
	// Event bit must reach irq only when unmasked, and clear by a one
	task automatic irq_event(input int b);
		reg_write(SGPS_OFS_IRQ_MASK, 32'h0);
		cyc(1);
		chk(irq, 1'b0);
		// The sticky bit itself must be set, not only some other one
		reg_read(SGPS_OFS_IRQ_STAT, rd);
		chk(rd[b], 1'b1);
		reg_write(SGPS_OFS_IRQ_MASK, 32'h1 << b);
		cyc(1);
		chk(irq, 1'b1);
		reg_write(SGPS_OFS_IRQ_STAT, 32'h1 << b);
		cyc(1);
		chk(irq, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		chk({pos_closed, pos_open, pos_transit, pos_faulted}, 4'h0);
		reg_read(SGPS_OFS_CTRL, rd);
		chk(rd, 32'h3);
		reg_read(SGPS_OFS_CLOSE_LEN, rd);
		chk(rd, {8'h00, LEN});
		reg_read(SGPS_OFS_OPEN_LEN, rd);
		chk(rd, {8'h00, LEN});
		// Read data stand one cycle only, then fall back to zero
		cyc(1);
		chk(reg_rdata, 32'h0);
		reg_read(SGPS_OFS_IRQ_MASK, rd);
		chk(rd, 32'h0);
		reg_read(8'h20, rd);
		chk(rd, 32'h0);
		cyc(8);
		chk(pos_open, 1'b1);
		chk(pos_code, SGPS_CODE_OPEN);
		$display("test reset done");
	endtask
	task automatic t_close_ok();
		pulse(1'b1);
		cyc(3);
		chk(pos_transit, 1'b1);
		chk(pos_code, SGPS_CODE_INTERMEDIATE);
		wait_end(1'b1);
		chk(pos_closed, 1'b1);
		cyc(1);
		chk(pos_transit, 1'b0);
		chk(pos_code, SGPS_CODE_CLOSED);
		irq_event(SGPS_EV_CLOSED);
		$display("test close ok done");
	endtask
	task automatic t_open_stuck();
		mode = 2'h1;
		pulse(1'b0);
		cyc(3);
		chk(pos_transit, 1'b1);
		cyc(19);
		chk({pos_transit, pos_faulted}, 2'h1);
		chk(pos_code, SGPS_CODE_FAULTED);
		cyc(10);
		chk(pos_faulted, 1'b1);
		irq_event(SGPS_EV_FAULT);
		mode = 2'h0;
		pulse(1'b0);
		cyc(2);
		chk(pos_faulted, 1'b0);
		wait_end(1'b0);
		chk(pos_open, 1'b1);
		cyc(1);
		chk(pos_code, SGPS_CODE_OPEN);
		$display("test open stuck done");
	endtask
	task automatic t_welded();
		mode = 2'h2;
		pulse(1'b1);
		cyc(6);
		chk({pos_closed, pos_open, pos_transit}, 3'h1);
		chk(pos_code, SGPS_CODE_INTERMEDIATE);
		reg_read(SGPS_OFS_STATUS, rd);
		chk(rd[7:6], 2'h1);
		pulse(1'b0);
		reg_read(SGPS_OFS_STATUS, rd);
		chk(rd[7:6], 2'h2);
		cyc(22);
		chk({pos_transit, pos_faulted}, 2'h1);
		chk(pos_code, SGPS_CODE_FAULTED);
		mode = 2'h0;
		pulse(1'b0);
		wait_end(1'b0);
		chk(pos_open, 1'b1);
		$display("test welded done");
	endtask
	task automatic t_single();
		reg_write(SGPS_OFS_CTRL, 32'h1);
		reg_write(SGPS_OFS_CLOSE_LEN, 32'h20);
		reg_read(SGPS_OFS_CLOSE_LEN, rd);
		chk(rd, 32'h20);
		pulse(1'b1);
		cyc(3);
		chk(pos_transit, 1'b1);
		wait_end(1'b1);
		chk(pos_closed, 1'b1);
		cyc(1);
		chk(pos_code, SGPS_CODE_CLOSED);
		// No contact wired reports disturbed; the open contact alone
		// reads closed while it is apart and no open travel runs
		reg_write(SGPS_OFS_CTRL, 32'h0);
		cyc(2);
		chk({pos_faulted, pos_code}, 3'h7);
		reg_write(SGPS_OFS_CTRL, 32'h2);
		cyc(2);
		chk(pos_code, SGPS_CODE_CLOSED);
		$display("test single contact done");
	endtask

	////////////////////////////////////////////////////////////////////////
	// Verdict, reached from the main sequence or the hang guard
	task automatic results();
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		#1;
		t_reset();
		t_close_ok();
		t_open_stuck();
		t_welded();
		t_single();
		results();
	end
endmodule
